// File: pcac_pkg.sv
// Constants for the counter array control and mode register block.
// Assumes an 8-bit special-function register port on the system clock.
// Function
// R1: Set overflow flag on counter wrap to zero
// R2: Flags cleared only by software writes
// R3: Overflow flag requests interrupt when enabled
// R4: Run bit six starts and stops counter
// R5: Six module flags set by match/capture
// R6: Enabled module flag requests interrupt
// R7: Idle bit seven suspends array in idle
// R8: Watchdog enable resets to one
// R9: Lock bit keeps watchdog enabled until reset
// R10: Timebase select picks counter tick source
// R11: External count input at most quarter rate
// R12: Watchdog enabled freezes other mode bits
// R13: Mode bit four reads zero always
// R14: Control register supports single-bit writes
// R15: Watchdog forces counter run, freezes settings
// R16: Writing one to module 5 flag forces reset
// R17: Counter advances one per selected tick
package pcac_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hd8;
  localparam logic [7:0] MODE_ADDR = 8'hd9;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h40;
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_WDT_FLAG_BIT = 5;
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_WDT_EN_BIT = 6;
  localparam int MODE_LOCK_BIT = 5;
  localparam int MODE_UNUSED_BIT = 4;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_OVF_IE_BIT = 0;
  localparam logic [7:0] MODE_WMASK = 8'hef;
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_TMR0 = 3'h2;
  localparam logic [2:0] TB_ECI = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_EXT8 = 3'h5;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [2:0] EXT8_LAST = 3'h7;
  localparam logic [15:0] CNT_MAX = 16'hffff;
endpackage

// File: pcac_tick.sv
// Timebase tick generator for the counter array.
// Assumes pin inputs are raw; they are synchronised here.
`timescale 1ns/10ps
module pcac_tick (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic [2:0] sel_i,
  input wire logic run_i,
  // Sources
  input wire logic tmr0_ovf_i,
  input wire logic ext_count_i,
  input wire logic ext_clk_i,
  // Tick
  output logic tick_o
);
  logic [3:0] div_reg, div_next;
  logic [2:0] ext8_reg, ext8_next;
  logic [2:0] eci_reg, eci_next;
  logic [2:0] ext_reg, ext_next;
  logic tick_reg, tick_next;
  logic eci_fall, ext_rise;

  always_comb
  begin
    eci_next = {eci_reg[1:0], ext_count_i};
    ext_next = {ext_reg[1:0], ext_clk_i};
    // Edges read only the second and third stages
    eci_fall = eci_reg[2] & ~eci_reg[1];
    ext_rise = ext_reg[1] & ~ext_reg[2];
    div_next = div_reg + 4'h1;
    if (div_reg == pcac_pkg::DIV12_LAST)
    begin
      div_next = 4'h0;
    end
    ext8_next = ext_rise ? ext8_reg + 3'h1 : ext8_reg;
    // R10: source selection
    case (sel_i)
      pcac_pkg::TB_DIV12: tick_next = (div_reg == pcac_pkg::DIV12_LAST);
      pcac_pkg::TB_DIV4: tick_next = (div_reg[1:0] == pcac_pkg::DIV4_LAST[1:0]);
      pcac_pkg::TB_TMR0: tick_next = tmr0_ovf_i;
      // R11: relies on slow count input
      pcac_pkg::TB_ECI: tick_next = eci_fall;
      pcac_pkg::TB_SYS: tick_next = 1'b1;
      pcac_pkg::TB_EXT8: tick_next = ext_rise && (ext8_reg == pcac_pkg::EXT8_LAST);
      default: tick_next = 1'b0;
    endcase
    tick_next = tick_next & run_i;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      div_reg <= 4'h0;
      ext8_reg <= 3'h0;
      eci_reg <= 3'h7;
      ext_reg <= 3'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      ext8_reg <= ext8_next;
      eci_reg <= eci_next;
      ext_reg <= ext_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

  // R10: system clock source ticks every cycle while run
  a_sys_tick: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
    (sel_i == pcac_pkg::TB_SYS && run_i) |=> tick_o)
    else $error("System clock tick missing");
endmodule // pcac_tick

// File: pcac_ctrl.sv
// Counter array control and mode registers with the main counter.
// Assumes a one-cycle special-function register write and read port.
`timescale 1ns/10ps
module pcac_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic sfr_bit_val_i,
  output logic [7:0] sfr_rdata_o,
  // Module events and enables
  input wire logic [5:0] module_event_i,
  input wire logic [5:0] module_int_en_i,
  // System
  input wire logic cpu_idle_i,
  input wire logic tmr0_ovf_i,
  input wire logic external_count_input_i,
  input wire logic ext_clk_i,
  // Status outputs
  output logic [15:0] count_o,
  output logic watchdog_enable_o,
  output logic irq_o,
  output logic wdt_force_reset_o
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] mode_reg, mode_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0] ctrl_wval;
  logic ctrl_wen, mode_wen, tick, run_eff, wdt_en;
  logic suspend;
  logic [7:0] rd_next, rd_reg;
  logic frc_reg, frc_next;

  assign wdt_en = mode_reg[pcac_pkg::MODE_WDT_EN_BIT];
  // R7: idle suspension stops ticks and module flags alike
  assign suspend = cpu_idle_i & mode_reg[pcac_pkg::MODE_IDLE_BIT];
  // R15: watchdog forces run; R7: idle suspend
  assign run_eff = (ctrl_reg[pcac_pkg::CTRL_RUN_BIT] | wdt_en)
    & ~suspend;

  pcac_tick u_tick (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(mode_reg[pcac_pkg::MODE_TB_LSB +: 3]),
    .run_i(run_eff),
    .tmr0_ovf_i(tmr0_ovf_i),
    .ext_count_i(external_count_input_i),
    .ext_clk_i(ext_clk_i),
    .tick_o(tick)
  );

  always_comb
  begin
    ctrl_wen = (sfr_addr_i == pcac_pkg::CTRL_ADDR) && (sfr_wr_i || sfr_bit_wr_i);
    mode_wen = (sfr_addr_i == pcac_pkg::MODE_ADDR) && sfr_wr_i;
    // R14: single-bit set and clear
    ctrl_wval = ctrl_reg;
    if (sfr_wr_i)
    begin
      ctrl_wval = sfr_wdata_i;
    end
    else
    begin
      ctrl_wval[sfr_bit_sel_i] = sfr_bit_val_i;
    end
    ctrl_next = ctrl_wen ? ctrl_wval : ctrl_reg;
    // R16: a written one, not a stored flag, forces the reset
    frc_next = 1'b0;
    if (ctrl_wen && wdt_en)
    begin
      if (sfr_wr_i)
      begin
        frc_next = sfr_wdata_i[pcac_pkg::CTRL_WDT_FLAG_BIT];
      end
      else
      begin
        frc_next = (sfr_bit_sel_i == pcac_pkg::CTRL_WDT_FLAG_BIT) && sfr_bit_val_i;
      end
    end
    // R17: one step per tick; R4: run control
    cnt_next = tick ? cnt_reg + 16'h1 : cnt_reg;
    // R1: wrap sets overflow flag, set wins over clear (R2)
    if (tick && cnt_reg == pcac_pkg::CNT_MAX)
    begin
      ctrl_next[pcac_pkg::CTRL_OVF_BIT] = 1'b1;
    end
    // R5: module events set flags, set wins (R2)
    if (!suspend)
    begin
      ctrl_next[5:0] = ctrl_next[5:0] | module_event_i;
    end
    mode_next = mode_reg;
    if (mode_wen)
    begin
      if (wdt_en)
      begin
        // R12: only the enable may change; R9: lock refuses its clear
        mode_next[pcac_pkg::MODE_WDT_EN_BIT] = sfr_wdata_i[pcac_pkg::MODE_WDT_EN_BIT]
          | mode_reg[pcac_pkg::MODE_LOCK_BIT];
      end
      else
      begin
        // R13: bit four never stored
        mode_next = sfr_wdata_i & pcac_pkg::MODE_WMASK;
        // Setting lock also enables the watchdog
        if (sfr_wdata_i[pcac_pkg::MODE_LOCK_BIT])
        begin
          mode_next[pcac_pkg::MODE_WDT_EN_BIT] = 1'b1;
        end
      end
    end
    case (sfr_addr_i)
      pcac_pkg::CTRL_ADDR: rd_next = ctrl_next;
      pcac_pkg::MODE_ADDR: rd_next = mode_next;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      // R8: watchdog on after reset
      ctrl_reg <= pcac_pkg::CTRL_RESET;
      mode_reg <= pcac_pkg::MODE_RESET;
      cnt_reg <= 16'h0000;
      rd_reg <= 8'h00;
      frc_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      frc_reg <= frc_next;
    end
  end

  assign sfr_rdata_o = rd_reg;
  assign count_o = cnt_reg;
  assign watchdog_enable_o = wdt_en;
  assign wdt_force_reset_o = frc_reg;
  // R3: overflow request; R6: module requests
  assign irq_o = (ctrl_reg[pcac_pkg::CTRL_OVF_BIT] & mode_reg[pcac_pkg::MODE_OVF_IE_BIT])
    | (|(ctrl_reg[5:0] & module_int_en_i));

  // Flags and interrupt request
  a_ovf_set: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
    (tick && cnt_reg == pcac_pkg::CNT_MAX) |=> ctrl_reg[7] && cnt_reg == 16'h0)
    else $error("Overflow flag not set on wrap");
  a_flag_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
    (ctrl_reg[7] && !ctrl_wen) |=> ctrl_reg[7])
    else $error("Overflow flag cleared by hardware");
  a_ovf_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R3
    (ctrl_reg[7] && mode_reg[0]) |-> irq_o)
    else $error("Overflow interrupt missing");
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R3
    (!ctrl_reg[7] && ctrl_reg[5:0] == 6'h00) |-> !irq_o)
    else $error("Interrupt without a set flag");
  a_mod_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
    (module_event_i[0] && !mode_reg[7]) |=> ctrl_reg[0])
    else $error("Module flag not set");
  a_mod_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
    (ctrl_reg[1] && module_int_en_i[1]) |-> irq_o)
    else $error("Module interrupt missing");
  a_idle_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
    (cpu_idle_i && mode_reg[7] && module_event_i[0] && !ctrl_reg[0] && !ctrl_wen)
    |=> !ctrl_reg[0])
    else $error("Module flag set while suspended");

  // Counter
  a_cnt_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
    (!ctrl_reg[6] && !wdt_en) [*3] |=> $stable(cnt_reg))
    else $error("Counter moved while stopped");
  a_run_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
    (sfr_wr_i && sfr_addr_i == pcac_pkg::CTRL_ADDR)
    |=> ctrl_reg[6] == $past(sfr_wdata_i[6]))
    else $error("Run bit not written");
  a_bit_wr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
    (sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == pcac_pkg::CTRL_ADDR && sfr_bit_sel_i == 3'h6)
    |=> ctrl_reg[6] == $past(sfr_bit_val_i))
    else $error("Single-bit write missed");
  a_cnt_step: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R17
    (cnt_reg != $past(cnt_reg)) |-> cnt_reg == $past(cnt_reg) + 16'h1)
    else $error("Counter skipped a value");
  a_idle_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
    (cpu_idle_i && mode_reg[7]) [*2] |=> $stable(cnt_reg))
    else $error("Counter ran in idle");
  a_wdt_run: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R15
    (wdt_en && !cpu_idle_i && mode_reg[3:1] == 3'h4) |=> ##1 (cnt_reg != $past(cnt_reg)))
    else $error("Watchdog did not force run");

  // Mode register and watchdog
  a_lock_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
    mode_reg[5] |=> mode_reg[6])
    else $error("Locked watchdog disabled");
  a_wdt_off: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
    (mode_wen && wdt_en && !mode_reg[5] && !sfr_wdata_i[6]) |=> !wdt_en)
    else $error("Unlocked watchdog not disabled");
  a_mode_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
    wdt_en |=> $stable(mode_reg[4:0]) && $stable(mode_reg[7]))
    else $error("Mode bits changed while watchdog on");
  a_bit4_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
    !mode_reg[4])
    else $error("Unused mode bit set");
  a_force_rst: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R16
    (wdt_en && sfr_wr_i && sfr_addr_i == pcac_pkg::CTRL_ADDR && sfr_wdata_i[5])
    |=> wdt_force_reset_o)
    else $error("Watchdog force reset missing");
  a_force_only: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R16
    (!wdt_en || !ctrl_wen || (sfr_bit_wr_i && !sfr_wr_i && sfr_bit_sel_i != 3'h5))
    |=> !wdt_force_reset_o)
    else $error("Watchdog reset forced without a flag write");

  c_wrap: cover property (@(posedge clk_i) tick && cnt_reg == 16'hffff);
  c_wdt_off: cover property (@(posedge clk_i) wdt_en ##1 !wdt_en);
  c_irq: cover property (@(posedge clk_i) irq_o);
  c_force: cover property (@(posedge clk_i) wdt_force_reset_o);
  c_idle: cover property (@(posedge clk_i) suspend && module_event_i[0]);
endmodule // pcac_ctrl

// File: test_counter_array_control_mode.sv
// Self-checking bench for the counter array control and mode registers.
// Assumes the bench alone drives every input of the block, with no far-side model.
`timescale 1ns/10ps
module test_counter_array_control_mode;
  localparam logic [7:0] CA = pcac_pkg::CTRL_ADDR;
  localparam logic [7:0] MA = pcac_pkg::MODE_ADDR;
  // Starts low so that time zero shows no false falling edge
  logic clk_i = 1'b0;
  logic sys_rst_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [2:0] sfr_bit_sel_i;
  logic [5:0] module_event_i, module_int_en_i;
  logic cpu_idle_i, tmr0_ovf_i, eci_i, ext_clk_i;
  logic [15:0] count_o, c0;
  logic watchdog_enable_o, irq_o, wdt_force_reset_o;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int pulses = 0;
  int p0;

  pcac_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i),
    .sfr_bit_sel_i(sfr_bit_sel_i), .sfr_bit_val_i(sfr_bit_val_i), .sfr_rdata_o(sfr_rdata_o),
    .module_event_i(module_event_i), .module_int_en_i(module_int_en_i),
    .cpu_idle_i(cpu_idle_i), .tmr0_ovf_i(tmr0_ovf_i), .external_count_input_i(eci_i),
    .ext_clk_i(ext_clk_i), .count_o(count_o), .watchdog_enable_o(watchdog_enable_o),
    .irq_o(irq_o), .wdt_force_reset_o(wdt_force_reset_o));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Hang guard; the wrap test alone needs nearly 65536 cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (wdt_force_reset_o === 1'b1)
      pulses <= pulses + 1;
    if (cycles == 90000)
    begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    cyc(1);
    sfr_wr_i = 1'b0;
    // Idle cycle keeps back-to-back strobes apart
    cyc(1);
  endtask

  task automatic bw(input logic [2:0] s, input logic v);
    sfr_addr_i = CA;
    sfr_bit_sel_i = s;
    sfr_bit_val_i = v;
    sfr_bit_wr_i = 1'b1;
    cyc(1);
    sfr_bit_wr_i = 1'b0;
    cyc(1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr_i = a;
    cyc(1);
    chk({8'h00, sfr_rdata_o}, {8'h00, exp});
  endtask

  // Counter advance over n cycles
  task automatic span(input int n, input logic [15:0] exp);
    c0 = count_o;
    cyc(n);
    chk(count_o - c0, exp);
  endtask

  initial
  begin
    {sys_rst_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, cpu_idle_i, tmr0_ovf_i} = 6'h20;
    {sfr_addr_i, sfr_wdata_i, sfr_bit_sel_i, ext_clk_i, eci_i} = 21'h000001;
    {module_event_i, module_int_en_i} = 12'h000;
    cyc(2);
    sys_rst_i = 1'b0;
    cyc(1);
    rdchk(CA, 8'h00);
    rdchk(MA, 8'h40);
    rdchk(8'hda, 8'h00);
    chk(watchdog_enable_o, 16'h0001);
    wr(MA, 8'h4f);
    rdchk(MA, 8'h40);
    wr(MA, 8'h1f);
    wr(MA, 8'h1f);
    rdchk(MA, 8'h0f);
    $display("end registers");
    wr(MA, 8'h08);
    bw(3'h6, 1'b1);
    cyc(2);
    span(20, 16'h0014);
    wr(MA, 8'h02);
    cyc(8);
    span(40, 16'h000a);
    wr(MA, 8'h00);
    cyc(24);
    span(48, 16'h0004);
    wr(MA, 8'h04);
    c0 = count_o;
    repeat (5)
    begin
      tmr0_ovf_i = 1'b1;
      cyc(1);
      tmr0_ovf_i = 1'b0;
      cyc(1);
    end
    cyc(3);
    chk(count_o - c0, 16'h0005);
    // Falling edges no closer than four system clocks
    wr(MA, 8'h06);
    cyc(4);
    c0 = count_o;
    repeat (6)
    begin
      eci_i = ~eci_i;
      cyc(4);
    end
    cyc(8);
    chk(count_o - c0, 16'h0003);
    wr(MA, 8'h0a);
    cyc(4);
    c0 = count_o;
    repeat (32)
    begin
      ext_clk_i = ~ext_clk_i;
      cyc(4);
    end
    cyc(8);
    chk(count_o - c0, 16'h0002);
    // Reserved code gives no ticks
    wr(MA, 8'h0c);
    cyc(2);
    span(20, 16'h0000);
    wr(MA, 8'h08);
    bw(3'h6, 1'b0);
    cyc(2);
    span(20, 16'h0000);
    bw(3'h6, 1'b1);
    wr(MA, 8'h88);
    cpu_idle_i = 1'b1;
    cyc(2);
    span(20, 16'h0000);
    module_event_i = 6'h01;
    rdchk(CA, 8'h40);
    module_event_i = 6'h00;
    wr(MA, 8'h08);
    cyc(2);
    span(20, 16'h0014);
    cpu_idle_i = 1'b0;
    $display("end timebase");
    for (int i = 0; i < 6; i++)
    begin
      module_event_i = 6'h01 << i;
      cyc(1);
    end
    module_event_i = 6'h00;
    cyc(3);
    rdchk(CA, 8'h7f);
    chk(irq_o, 16'h0000);
    module_int_en_i = 6'h20;
    cyc(1);
    chk(irq_o, 16'h0001);
    wr(CA, 8'h40);
    rdchk(CA, 8'h40);
    chk(irq_o, 16'h0000);
    bw(3'h3, 1'b1);
    rdchk(CA, 8'h48);
    bw(3'h3, 1'b0);
    $display("end flags");
    while (count_o !== 16'hffff)
      cyc(1);
    cyc(2);
    rdchk(CA, 8'hc0);
    chk(irq_o, 16'h0000);
    wr(MA, 8'h09);
    cyc(5);
    chk(irq_o, 16'h0001);
    rdchk(CA, 8'hc0);
    bw(3'h7, 1'b0);
    chk(irq_o, 16'h0000);
    $display("end wrap");
    bw(3'h6, 1'b0);
    wr(MA, 8'h48);
    rdchk(MA, 8'h48);
    cyc(2);
    span(20, 16'h0014);
    wr(MA, 8'h80);
    rdchk(MA, 8'h08);
    wr(MA, 8'h48);
    wr(MA, 8'h40);
    rdchk(MA, 8'h48);
    p0 = pulses;
    bw(3'h5, 1'b1);
    cyc(3);
    chk(16'(pulses - p0), 16'h0001);
    wr(MA, 8'h08);
    wr(MA, 8'h28);
    rdchk(MA, 8'h68);
    wr(MA, 8'h08);
    rdchk(MA, 8'h68);
    chk(watchdog_enable_o, 16'h0001);
    sys_rst_i = 1'b1;
    cyc(2);
    sys_rst_i = 1'b0;
    cyc(1);
    rdchk(MA, 8'h40);
    $display("end watchdog");
    finish_test();
  end
endmodule // test_counter_array_control_mode
